// file: dv/mefm_arith_model.sv
// behavioural arithmetic block that publishes its error status bits
`timescale 1ns/1ps

module mefm_arith_model
(
    // clock
    input wire logic clk_i,
    // execution request from the bench
    input wire logic go_i,
    input wire logic slow_i,
    input wire logic [7:0] blk_i,
    input wire logic div_i,
    input wire logic ovf_i,
    // status seen by the monitor
    output mefm_pkg::mefm_arith_t arith_o
);
    import mefm_pkg::*;

    mefm_arith_t pend_q = '0; // result held back for a slow answer

    initial arith_o = '0;

    // status bits are set at the end of every execution; between ends they
    // keep changing so that a monitor reading stale bits cannot pass by luck
    always @(posedge clk_i)
    begin
        if (go_i && !slow_i)
            arith_o <= {1'b1, blk_i, div_i, ovf_i};
        else if (pend_q.done)
            arith_o <= pend_q;
        else
            arith_o <= {1'b0, ~arith_o.blk, ~arith_o.div_zero, ~arith_o.overflow_bit};
        pend_q <= {go_i && slow_i, blk_i, div_i, ovf_i}; // slow: one cycle later
    end
endmodule // mefm_arith_model

// file: dv/mefm_top_tb.sv
// self-checking bench for the math error flag monitor
`timescale 1ns/1ps

module mefm_top_tb;
    import mefm_pkg::*;

    // design inputs, all valued at time zero
    logic clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
    logic en_i = 1'b0, clr_i = 1'b0, eval_i = 1'b0, we_i = 1'b0, re_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic [DATA_W-1:0] rdata_o;
    logic err_o, irq_o;
    mefm_arith_t arith; // status from the partner model
    // partner requests
    logic go = 1'b0, slow = 1'b0, m_div = 1'b0, m_ovf = 1'b0;
    logic [BLK_W-1:0] m_blk = '0;
    // reference state
    mefm_cfg_t cfg_m;
    logic cap_d, cap_o, exp_err, mt, hd, ho, hit;
    logic [DATA_W-1:0] cw;
    int mismatches = 0, n_checks = 0, cyc = 0;
    integer seed = 32'hd937f247;

    always #12.5 clk_i = ~clk_i;

    mefm_arith_model partner (.clk_i(clk_i), .go_i(go), .slow_i(slow), .blk_i(m_blk),
        .div_i(m_div), .ovf_i(m_ovf), .arith_o(arith));
    mefm_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .en_i(en_i),
        .clr_i(clr_i), .eval_i(eval_i), .arith_i(arith), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .err_o(err_o), .irq_o(irq_o));

    // compare one value, count it, report a mismatch at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one-cycle write, the slave never stalls
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    // one-cycle read; data appear in the following cycle and hold until the next read
    task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, string w);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 check(rdata_o, e, w);
    endtask

    // one scan: execution before and/or after the monitor's turn, then an idle
    // cycle whose clock enable is random so frozen cycles are exercised too
    task automatic scan(bit pre, bit post, bit en, bit clr, bit d, bit o, logic [7:0] b, bit s);
        @(posedge clk_i);
        go <= pre;
        m_div <= d;
        m_ovf <= o;
        m_blk <= b;
        slow <= s;
        @(posedge clk_i);
        go <= post;
        eval_i <= 1'b1;
        en_i <= en;
        clr_i <= clr;
        @(posedge clk_i);
        go <= 1'b0;
        eval_i <= 1'b0;
        clr_i <= 1'b0;
        ce_i <= ($random(seed) % 5) != 0;
        @(posedge clk_i);
        ce_i <= 1'b1;
    endtask

    // cycle ceiling, far above the two thousand or so cycles the tests need
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc >= 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // reference monitor: reads the inputs as they stood before the edge
    always @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            cfg_m = '0;
            cap_d = 1'b0;
            cap_o = 1'b0;
            exp_err = 1'b0;
        end
        else if (ce_i)
        begin
            mt = arith.done && arith.blk == cfg_m.blk && cfg_m.blk != NULL_BLK;
            hd = mt ? arith.div_zero : cap_d;
            ho = mt ? arith.overflow_bit : cap_o;
            hit = cfg_m.sel == SEL_DIV ? hd : cfg_m.sel == SEL_OVF ? ho :
                  cfg_m.sel == SEL_ANY ? (hd | ho) : 1'b0;
            if (cfg_m.blk == NULL_BLK || clr_i)
                exp_err = 1'b0;
            else if (eval_i && en_i)
                exp_err = cfg_m.auto_clr ? hit : (exp_err | hit);
            cap_d = hd;
            cap_o = ho;
            if (we_i && addr_i == REG_CFG)
                cfg_m = wdata_i[CFG_W-1:0];
        end
    end

    // error output checked in every cycle out of reset, where it has settled
    always @(negedge clk_i)
        if (reset_n_i)
            check(err_o, exp_err, "err_o");

    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        bus_rd(REG_CFG, '0, "cfg reset");
        bus_rd(REG_IMSK, '0, "imsk reset");
        bus_wr(4'h1, 32'hffffffff);
        bus_rd(4'h1, '0, "unmapped");
        $display("test registers done");
        // latched, either error, block 5: event set but masked, then unmasked
        bus_wr(REG_CFG, 32'h205);
        scan(1, 0, 1, 0, 1, 0, 8'h05, 0);
        #1 check(irq_o, 1'b0, "irq masked");
        bus_rd(REG_IST, 32'h3, "ist");
        bus_rd(REG_STAT, 32'h3, "stat");
        bus_wr(REG_IMSK, 32'h1);
        #1 check(irq_o, 1'b1, "irq raised");
        bus_wr(REG_IST, 32'h3);
        #1 check(irq_o, 1'b0, "irq cleared");
        bus_rd(REG_IST, '0, "ist cleared");
        $display("test interrupt done");
        // random scans with occasional reconfiguration
        repeat (400)
        begin
            if ($random(seed) % 6 == 0)
            begin
                cw = {21'h0, 1'($random(seed)), 2'($random(seed)), 6'h0, 2'($random(seed))};
                bus_wr(REG_CFG, cw);
                bus_rd(REG_CFG, cw, "cfg");
            end
            scan($random(seed), $random(seed), ($random(seed) % 4) != 0,
                 ($random(seed) % 5) == 0, $random(seed), $random(seed),
                 ($random(seed) % 2) ? {6'h0, cfg_m.blk[1:0]} : {6'h0, 2'($random(seed))},
                 ($random(seed) % 4) == 0);
        end
        $display("test random scans done");
        tally_and_finish();
    end
endmodule // mefm_top_tb

// file: rtl/mefm_pkg.sv
// constants and types shared by the math error flag monitor
package mefm_pkg;

    // register port geometry
    localparam int ADDR_W = 4; // byte address width
    localparam int DATA_W = 32; // register data width
    localparam int BLK_W = 8; // width of a block number

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CFG = 4'h0; // configuration
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h4; // live state, read only
    localparam logic [ADDR_W-1:0] REG_IST = 4'h8; // sticky events, write one to clear
    localparam logic [ADDR_W-1:0] REG_IMSK = 4'hc; // interrupt mask

    // configuration field layout
    localparam int CFG_BLK_LSB = 0; // watched_block_number field
    localparam int CFG_SEL_LSB = 8; // error select field, two bits
    localparam int CFG_AUTO_BIT = 10; // automatic clear enable
    localparam int CFG_W = 11; // used width of the configuration word
    localparam logic [CFG_W-1:0] CFG_RST = 11'h000; // no block watched after reset

    // status field layout
    localparam int STAT_ERR_BIT = 0; // error output
    localparam int STAT_DIV_BIT = 1; // last captured division-by-zero bit
    localparam int STAT_OVF_BIT = 2; // last captured overflow_bit
    localparam int STAT_W = 3; // used width of the status word

    // interrupt event layout, shared by status and mask
    localparam int IRQ_RISE_BIT = 0; // error output went high
    localparam int IRQ_HIT_BIT = 1; // an evaluation found the selected error
    localparam int IRQ_W = 2; // number of events
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0; // events and mask reset value

    // block number that stands for no block at all
    localparam logic [BLK_W-1:0] NULL_BLK = 8'h00;

    // error select encoding
    typedef enum logic [1:0] {
        SEL_DIV = 2'h0, // division by zero only
        SEL_OVF = 2'h1, // overflow only
        SEL_ANY = 2'h2 // either of the two
    } mefm_sel_t;

    // status the arithmetic block publishes at the end of an execution
    typedef struct packed {
        logic done; // one-cycle pulse: execution finished
        logic [BLK_W-1:0] blk; // number of the block that executed
        logic div_zero; // 1 when it divided by zero
        logic overflow_bit; // 1 when it overflowed
    } mefm_arith_t;

    // configuration word, fields listed from the top bit down to bit 0
    typedef struct packed {
        logic auto_clr; // clear before each evaluation
        logic [1:0] sel; // error select
        logic [BLK_W-1:0] blk; // watched_block_number
    } mefm_cfg_t;

endpackage

// file: rtl/mefm_top.sv
// math error flag monitor with register port and interrupt
//
// Contract
// - evaluate only while enable is high
// - configuration names watched block by number
// - select division, overflow, or either
// - output high when selected error last occurred
// - division select: output follows division bit
// - overflow select: output follows overflow bit
// - either select: output is OR of bits
// - automatic clear: cleared before each evaluation
// - otherwise output latches until clear input
// - earlier execution reported in same scan
// - later execution reported one scan later
// - no watched block: output stays low
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps

module mefm_top
(
    // clock, reset, freeze
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // monitor controls
    input wire logic en_i,
    input wire logic clr_i,
    input wire logic eval_i,
    // watched arithmetic block
    input wire mefm_pkg::mefm_arith_t arith_i,
    // register port
    input wire logic [mefm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [mefm_pkg::DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [mefm_pkg::DATA_W-1:0] rdata_o,
    // results
    output logic err_o,
    output logic irq_o
);
    import mefm_pkg::*;

    // selected error condition from the two status bits
    function automatic logic sel_hit(input logic [1:0] sel, input logic dz, input logic ov);
        logic r;
        r = 1'b0;
        unique case (sel)
            // division and overflow selects look at their own bit only; either select ORs both
            SEL_DIV: r = dz;
            SEL_OVF: r = ov;
            SEL_ANY: r = dz | ov;
            default: r = 1'b0; // unused code never reports
        endcase
        return r;
    endfunction

    // state
    mefm_cfg_t cfg_q, cfg_d; // configuration register
    logic div_q, div_d; // last division-by-zero bit of the watched block
    logic ovf_q, ovf_d; // last overflow_bit of the watched block
    logic err_q, err_d; // error output
    logic [IRQ_W-1:0] ist_q, ist_d; // sticky events
    logic [IRQ_W-1:0] imsk_q, imsk_d; // interrupt mask
    logic [DATA_W-1:0] rdata_q, rdata_d; // read data, valid one cycle after the strobe

    // decode
    logic null_ref; // no block is watched
    logic match; // the watched block finished right now
    logic cur_div; // division bit including a same-cycle finish
    logic cur_ovf; // overflow bit including a same-cycle finish
    logic do_eval; // monitor takes its turn in the scan
    logic hit; // selected error present
    logic [IRQ_W-1:0] ev; // events raised this cycle
    logic [IRQ_W-1:0] w1c; // bits software clears this cycle

    // the watched block is picked out by number; zero stands for none
    always_comb
    begin
        null_ref = (cfg_q.blk == NULL_BLK);
        match = arith_i.done && (arith_i.blk == cfg_q.blk) && !null_ref;
        // a finish in the monitor's own cycle counts as earlier in the scan
        cur_div = match ? arith_i.div_zero : div_q;
        cur_ovf = match ? arith_i.overflow_bit : ovf_q;
        do_eval = eval_i && en_i;
        hit = sel_hit(cfg_q.sel, cur_div, cur_ovf);
    end

    // capture the bits the arithmetic block leaves behind after each run
    always_comb
    begin
        div_d = div_q;
        ovf_d = ovf_q;
        if (match)
        begin
            // both bits are rewritten by every execution, so no merge is needed
            div_d = arith_i.div_zero;
            ovf_d = arith_i.overflow_bit;
        end
    end

    // error output; it only moves on the monitor's turn, on a clear, or when no block is watched
    always_comb
    begin
        err_d = err_q;
        if (null_ref)
        begin
            err_d = 1'b0;
        end
        else if (clr_i)
        begin
            err_d = 1'b0;
        end
        else if (do_eval)
        begin
            if (cfg_q.auto_clr)
            begin
                err_d = hit;
            end
            else
            begin
                err_d = err_q | hit;
            end
        end
        // a finish after the monitor's turn waits for the next turn
    end

    // configuration, mask and sticky events from the register port
    always_comb
    begin
        cfg_d = cfg_q;
        imsk_d = imsk_q;
        w1c = '0;
        if (we_i && (addr_i == REG_CFG))
        begin
            cfg_d = mefm_cfg_t'(wdata_i[CFG_W-1:0]);
        end
        if (we_i && (addr_i == REG_IMSK))
        begin
            imsk_d = wdata_i[IRQ_W-1:0];
        end
        if (we_i && (addr_i == REG_IST))
        begin
            w1c = wdata_i[IRQ_W-1:0];
        end
        ev = '0;
        ev[IRQ_RISE_BIT] = err_d && !err_q;
        ev[IRQ_HIT_BIT] = do_eval && hit && !null_ref;
        // an event in the clearing cycle survives the clear
        ist_d = (ist_q & ~w1c) | ev;
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_d = rdata_q;
        if (re_i)
        begin
            rdata_d = '0;
            unique case (addr_i)
                REG_CFG: rdata_d[CFG_W-1:0] = cfg_q;
                REG_STAT:
                begin
                    rdata_d[STAT_ERR_BIT] = err_q;
                    rdata_d[STAT_DIV_BIT] = div_q;
                    rdata_d[STAT_OVF_BIT] = ovf_q;
                end
                REG_IST: rdata_d[IRQ_W-1:0] = ist_q;
                REG_IMSK: rdata_d[IRQ_W-1:0] = imsk_q;
                default: rdata_d = '0;
            endcase
        end
    end

    // all state; a low clock enable freezes every flop
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            cfg_q <= mefm_cfg_t'(CFG_RST);
            div_q <= 1'b0;
            ovf_q <= 1'b0;
            err_q <= 1'b0;
            ist_q <= IRQ_RST;
            imsk_q <= IRQ_RST;
            rdata_q <= '0;
        end
        else if (ce_i)
        begin
            cfg_q <= cfg_d;
            div_q <= div_d;
            ovf_q <= ovf_d;
            err_q <= err_d;
            ist_q <= ist_d;
            imsk_q <= imsk_d;
            rdata_q <= rdata_d;
        end
    end

    // outputs
    assign err_o = err_q;
    assign rdata_o = rdata_q;
    assign irq_o = |(ist_q & imsk_q); // level, high while an unmasked event stands

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // helper: an evaluation that is free to update the output
    logic live_eval;
    assign live_eval = ce_i && do_eval && !clr_i && !null_ref;

    null_low_a: assert property ($past(ce_i) && $past(null_ref) |-> !err_q)
        else $error("output high with no watched block");
    en_gate_a: assert property (ce_i && !en_i && !clr_i && !null_ref |=> $stable(err_q))
        else $error("output moved while disabled");
    div_sel_a: assert property (live_eval && cfg_q.auto_clr && cfg_q.sel == SEL_DIV
        |=> err_q == $past(cur_div))
        else $error("division select does not follow division bit");
    ovf_sel_a: assert property (live_eval && cfg_q.auto_clr && cfg_q.sel == SEL_OVF
        |=> err_q == $past(cur_ovf))
        else $error("overflow select does not follow overflow bit");
    any_sel_a: assert property (live_eval && cfg_q.sel == SEL_ANY && cfg_q.auto_clr
        |=> err_q == ($past(cur_div) | $past(cur_ovf)))
        else $error("either select is not the OR of both bits");
    auto_clr_a: assert property (live_eval && cfg_q.auto_clr && !hit |=> !err_q)
        else $error("automatic clear did not clear");
    latch_hold_a: assert property (ce_i && err_q && !cfg_q.auto_clr && !clr_i && !null_ref
        |=> err_q)
        else $error("latched output dropped without clear");
    clr_prio_a: assert property (ce_i && clr_i |=> !err_q)
        else $error("clear did not win");
    hit_set_a: assert property (live_eval && hit |=> err_q ##1 (err_q || $past(clr_i)
        || !$past(ce_i) || $past(do_eval) || $past(null_ref)))
        else $error("selected error not reported");
    same_scan_a: assert property (live_eval && match && cfg_q.sel == SEL_DIV
        && arith_i.div_zero |=> err_q)
        else $error("same-cycle finish missed");
    late_run_a: assert property (ce_i && !do_eval && !clr_i && !null_ref
        |=> $stable(err_q))
        else $error("output moved outside the monitor turn");
    ref_pick_a: assert property (ce_i && arith_i.done && arith_i.blk != cfg_q.blk
        |=> $stable(div_q) && $stable(ovf_q))
        else $error("other block changed captured bits");

    // main scenarios
    auto_hit_c: cover property (live_eval && cfg_q.auto_clr && hit ##[1:20] live_eval && !hit);
    latch_c: cover property (live_eval && !cfg_q.auto_clr && hit ##[1:20] ce_i && clr_i);
    clr_clash_c: cover property (ce_i && do_eval && hit && clr_i && !null_ref);
    any_sel_c: cover property (live_eval && cfg_q.sel == SEL_ANY && cur_div && cur_ovf);
    irq_c: cover property (ce_i && irq_o ##1 !irq_o);

endmodule // mefm_top
